// [common/pm_cfg.svh]
// Constants of the management serial target
// Operation
// R1 - The target speaks the power-management bus protocol at revision 1.2 while the converter runs.
// R2 - Packet error codes are checked on received packets and appended to transmitted ones.
// R3 - The device drives the alert line low to announce new status information.
// R4 - After reset every fault and warning condition is enabled to pull the alert low.
// R5 - Each fault and warning condition has its own mask that keeps it off the alert line; a timeout raises alert whatever the mask.
// R6 - Data, clock and alert are open-drain: the device only pulls low or releases them.
// R7 - Telemetry and limit values are encoded and decoded in the LINEAR number format.
// R8 - Output-voltage values are taken and reported with the exponent that the mode setting holds.
// R9 - Temperature 1 reports the external power stages and temperature 2 the controller die.
// R10 - Up to four external stage temperatures are accepted beside the die temperature.
// R11 - The device's total clock stretching within one message stays within 25 ms.
// R12 - Stretching starts only after the device has driven an acknowledge, and ends when done.
// R13 - A clock held low past the timeout resets the link logic, frees both lines and raises alert.
// R14 - The host waits for a stretched clock to be released before the next clock pulse.
// R15 - The alert stays asserted until the host clears faults or reads the alert response address.
`ifndef PM_CFG_SVH
`define PM_CFG_SVH

// ********************************************************************
// Timing
// ********************************************************************
`define PM_CLK_KHZ 100000
`define PM_TIMEOUT_MS 25
`define PM_SEXT_MS 25
`define PM_STRETCH_CYC 16
`define PM_CNT_W 24

// ********************************************************************
// Addresses and commands
// ********************************************************************
`define PM_DEV_ADDR 7'h40
`define PM_ARA_ADDR 7'h0C
`define PM_CMD_CLEAR 8'h03
`define PM_CMD_MASK 8'h1B
`define PM_CMD_MODE 8'h20
`define PM_CMD_VOUT 8'h21
`define PM_CMD_OTWARN 8'h51
`define PM_CMD_STATUS 8'h78
`define PM_CMD_TEMP1 8'h8D
`define PM_CMD_TEMP2 8'h8E

// ********************************************************************
// Fields and reset values
// ********************************************************************
`define PM_MAX_STAGES 4
`define PM_BYTE_BITS 4'h8
`define PM_LAST_BIT 4'h7
`define PM_MODE_LINEAR 3'h0
`define PM_MODE_RST 8'h17
`define PM_VOUT_RST 16'h0000
`define PM_OTLIM_RST 16'h03FF
`define PM_MASK_RST 8'h00
`define PM_TEMP_EXP 5'h00
`define PM_ST_CML 0
`define PM_ST_OT 1
`define PM_N_EXT 6
`define PM_CRC_POLY 8'h07
`define PM_IDLE_BYTE 8'hFF

`endif

// [common/pm_pkg.sv]
// Types shared by the management serial target
`include "pm_cfg.svh"
package pm_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_RX    = 3'h1,
        ST_ACK   = 3'h3,
        ST_TX    = 3'h2,
        ST_TXACK = 3'h6,
        ST_IGN   = 3'h7
    } link_state_e;

    typedef struct packed {
        logic [`PM_MAX_STAGES-1:0][10:0] ext_temp;
        logic [10:0] die_temp;
    } telemetry_s;

    typedef struct packed {
        logic [4:0] exponent;
        logic [15:0] mantissa;
    } vout_set_s;

endpackage

// [verilog/pm_sync.sv]
// Two-stage synchroniser for the bus pins
module pm_sync #(
    parameter int W = 2
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    // Lines idle high, so reset to released
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '1;
            o_q <= '1;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule

// [verilog/pm_serial_target.sv]
// Management serial target: byte engine, command set, alert and timeouts
`include "pm_cfg.svh"
module pm_serial_target #(
    parameter logic [6:0] DEV_ADDR = `PM_DEV_ADDR,
    parameter int N_STAGES = `PM_MAX_STAGES,
    parameter int STRETCH_CYC = `PM_STRETCH_CYC,
    parameter int TIMEOUT_CYC = `PM_TIMEOUT_MS * `PM_CLK_KHZ,
    parameter int SEXT_CYC = `PM_SEXT_MS * `PM_CLK_KHZ
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_scl,
    output logic o_scl,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    output logic o_alert_output_line,
    output logic o_alert_output_line_oe,
    input wire pm_pkg::telemetry_s i_telemetry,
    input wire logic [`PM_N_EXT-1:0] i_cond_set,
    output pm_pkg::vout_set_s o_vout,
    output logic [7:0] o_status
);
    localparam int CW = `PM_CNT_W;
    localparam logic [CW-1:0] TO_LIM = CW'(TIMEOUT_CYC);
    localparam logic [CW-1:0] SEXT_LIM = CW'(SEXT_CYC);
    localparam logic [CW-1:0] STR_LEN = CW'(STRETCH_CYC);

    // ****************************************************************
    // Reset release and pin sampling
    // ****************************************************************
    logic rst_meta_r, rst_n;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    logic [1:0] pins_s;
    pm_sync #(.W(2)) u_sync (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_d({i_scl, i_sda}),
        .o_q(pins_s)
    );
    wire scl_s = pins_s[1];
    wire sda_s = pins_s[0];
    logic scl_d_r, sda_d_r;
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_w = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_w = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ****************************************************************
    // State
    // ****************************************************************
    pm_pkg::link_state_e state_r, state_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt, crc_r, crc_nxt, cmd_r, cmd_nxt, d0_r, d0_nxt, d1_r, d1_nxt;
    logic first_r, first_nxt, rd_r, rd_nxt, ara_r, ara_nxt, msg_r, msg_nxt;
    logic cmdv_r, cmdv_nxt, mack_r, mack_nxt, sda_oe_r, sda_oe_nxt;
    logic [1:0] nrx_r, nrx_nxt, idx_r, idx_nxt;
    logic [CW-1:0] str_r, str_nxt, stot_r, stot_nxt, low_r, low_nxt;
    logic scl_oe_r, str_go, ara_hit;
    logic [7:0] mode_r, mask_r, status_r;
    logic [15:0] vout_r, otlim_r;
    logic alert_r;

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ `PM_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // LINEAR word to whole units
    function automatic logic signed [31:0] lin_dec(input logic [15:0] w);
        logic signed [31:0] m;
        logic signed [4:0] e;
        m = 32'(signed'(w[10:0]));
        e = signed'(w[15:11]);
        return (e < 0) ? (m >>> (-e)) : (m <<< e);
    endfunction

    // ****************************************************************
    // Telemetry
    // ****************************************************************
    logic [10:0] temp1;
    always_comb begin
        temp1 = i_telemetry.ext_temp[0];
        for (int i = 1; i < N_STAGES; i++) begin
            if ($signed(i_telemetry.ext_temp[i]) > $signed(temp1)) begin // [R10]
                temp1 = i_telemetry.ext_temp[i];
            end
        end
    end
    wire [15:0] temp1_w = {`PM_TEMP_EXP, temp1}; // [R7] [R9]
    wire [15:0] temp2_w = {`PM_TEMP_EXP, i_telemetry.die_temp}; // [R9]
    wire ot_hit = 32'(signed'(temp1)) > lin_dec(otlim_r); // [R7]

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [15:0] rd_word;
    logic [1:0] rd_len;
    always_comb begin
        rd_word = 16'h0000;
        rd_len = 2'h2;
        if (ara_r) begin
            rd_word = {8'h00, DEV_ADDR, 1'b0};
            rd_len = 2'h1;
        end else begin
            unique case (cmd_r) // [R1]
                `PM_CMD_MODE: begin rd_word = {8'h00, mode_r}; rd_len = 2'h1; end
                `PM_CMD_VOUT: rd_word = vout_r; // [R8]
                `PM_CMD_MASK: begin rd_word = {8'h00, mask_r}; rd_len = 2'h1; end
                `PM_CMD_OTWARN: rd_word = otlim_r;
                `PM_CMD_STATUS: begin rd_word = {8'h00, status_r}; rd_len = 2'h1; end
                `PM_CMD_TEMP1: rd_word = temp1_w; // [R9]
                `PM_CMD_TEMP2: rd_word = temp2_w; // [R9]
                default: rd_len = 2'h0;
            endcase
        end
    end
    // Low byte first, then the error code, then idle bytes
    wire [7:0] tx_byte = (idx_r < rd_len) ? (idx_r[0] ? rd_word[15:8] : rd_word[7:0])
                       : (idx_r == rd_len) ? crc_r : `PM_IDLE_BYTE; // [R2]

    wire addr_dev = sh_r[7:1] == DEV_ADDR;
    wire addr_ara = (sh_r[7:1] == `PM_ARA_ADDR) & sh_r[0];
    wire to_hit = low_r == TO_LIM;

    // ****************************************************************
    // Byte engine
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        first_nxt = first_r;
        rd_nxt = rd_r;
        ara_nxt = ara_r;
        msg_nxt = msg_r;
        crc_nxt = crc_r;
        cmd_nxt = cmd_r;
        cmdv_nxt = cmdv_r;
        nrx_nxt = nrx_r;
        d0_nxt = d0_r;
        d1_nxt = d1_r;
        idx_nxt = idx_r;
        mack_nxt = mack_r;
        sda_oe_nxt = sda_oe_r;
        str_go = 1'b0;
        ara_hit = 1'b0;
        if (to_hit) begin
            state_nxt = pm_pkg::ST_IDLE; // [R13]
            msg_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
        end else if (start_w) begin
            state_nxt = pm_pkg::ST_RX;
            bit_nxt = 4'h0;
            first_nxt = 1'b1;
            rd_nxt = 1'b0;
            ara_nxt = 1'b0;
            idx_nxt = 2'h0;
            msg_nxt = 1'b1;
            sda_oe_nxt = 1'b0;
            if (!msg_r) begin
                crc_nxt = 8'h00; // Repeated start keeps the code running
                cmdv_nxt = 1'b0;
                nrx_nxt = 2'h0;
            end
        end else if (stop_w) begin
            state_nxt = pm_pkg::ST_IDLE;
            msg_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
        end else begin
            unique case (state_r)
                pm_pkg::ST_IDLE, pm_pkg::ST_IGN: ;
                pm_pkg::ST_RX: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        bit_nxt = bit_r + 4'h1;
                    end else if (scl_fall && bit_r == `PM_BYTE_BITS) begin
                        if (first_r && !(addr_dev || addr_ara)) begin
                            state_nxt = pm_pkg::ST_IGN;
                        end else begin
                            state_nxt = pm_pkg::ST_ACK;
                            sda_oe_nxt = 1'b1;
                            crc_nxt = crc8(crc_r, sh_r); // [R2]
                            first_nxt = 1'b0;
                            if (first_r) begin
                                rd_nxt = sh_r[0];
                                ara_nxt = addr_ara;
                                ara_hit = addr_ara; // [R15]
                            end else if (!cmdv_r) begin
                                cmd_nxt = sh_r;
                                cmdv_nxt = 1'b1;
                            end else begin
                                if (nrx_r == 2'h0) d0_nxt = sh_r;
                                if (nrx_r == 2'h1) d1_nxt = sh_r;
                                if (nrx_r != 2'h3) nrx_nxt = nrx_r + 2'h1;
                            end
                        end
                    end
                end
                pm_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_nxt = 4'h0;
                        if (rd_r) begin
                            state_nxt = pm_pkg::ST_TX;
                            sh_nxt = tx_byte;
                            crc_nxt = crc8(crc_r, tx_byte); // [R2]
                            idx_nxt = idx_r + 2'h1;
                            sda_oe_nxt = ~tx_byte[7];
                        end else begin
                            state_nxt = pm_pkg::ST_RX;
                            sda_oe_nxt = 1'b0;
                            str_go = 1'b1; // [R12]
                        end
                    end
                end
                pm_pkg::ST_TX: begin
                    if (scl_fall && bit_r == `PM_LAST_BIT) begin
                        state_nxt = pm_pkg::ST_TXACK;
                        sda_oe_nxt = 1'b0;
                    end else if (scl_fall) begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        bit_nxt = bit_r + 4'h1;
                        sda_oe_nxt = ~sh_r[6];
                    end
                end
                pm_pkg::ST_TXACK: begin
                    if (scl_rise) begin
                        mack_nxt = ~sda_s;
                    end else if (scl_fall && !mack_r) begin
                        state_nxt = pm_pkg::ST_IGN;
                    end else if (scl_fall) begin
                        state_nxt = pm_pkg::ST_TX;
                        bit_nxt = 4'h0;
                        sh_nxt = tx_byte;
                        crc_nxt = crc8(crc_r, tx_byte); // [R2]
                        if (idx_r != 2'h3) idx_nxt = idx_r + 2'h1;
                        sda_oe_nxt = ~tx_byte[7];
                    end
                end
                default: state_nxt = pm_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Stretch budget and clock-low watchdog
    // ****************************************************************
    // One cycle of the budget held back so one message never exceeds the limit
    wire str_ok = stot_r < (SEXT_LIM - CW'(1));
    assign str_nxt = to_hit ? '0 : (str_go && str_ok) ? STR_LEN // [R11] [R12]
                   : (str_r != '0 && str_ok) ? str_r - CW'(1) : '0;
    assign stot_nxt = (start_w && !msg_r) ? '0 : stot_r + CW'(scl_oe_r); // [R11]
    assign low_nxt = scl_s ? '0 : to_hit ? low_r : low_r + CW'(1); // [R13]

    // ****************************************************************
    // Command commit and status
    // ****************************************************************
    logic [1:0] exp_len;
    logic len_bad;
    always_comb begin
        exp_len = 2'h0;
        len_bad = 1'b0;
        unique case (cmd_r)
            `PM_CMD_CLEAR: exp_len = 2'h0;
            `PM_CMD_MODE, `PM_CMD_MASK: exp_len = 2'h1;
            `PM_CMD_VOUT, `PM_CMD_OTWARN: exp_len = 2'h2;
            default: len_bad = 1'b1;
        endcase
    end
    wire wr_end = stop_w & msg_r & cmdv_r & ~rd_r;
    wire len_ok = nrx_r == exp_len;
    wire pec_ok = (nrx_r == exp_len + 2'h1) && (crc_r == 8'h00); // [R2]
    wire mode_ok = (cmd_r != `PM_CMD_MODE) || (d0_r[7:5] == `PM_MODE_LINEAR); // [R8]
    wire do_wr = wr_end & (len_ok | pec_ok) & ~len_bad & mode_ok;
    wire clr_w = do_wr & (cmd_r == `PM_CMD_CLEAR);
    wire [7:0] ev_set = {i_cond_set, ot_hit, (wr_end & ~do_wr) | to_hit};
    wire [7:0] status_nxt = (status_r & ~{8{clr_w}}) | ev_set; // Set wins over clear
    wire alert_nxt = (alert_r & ~clr_w & ~ara_hit) | (|(ev_set & ~mask_r)) | to_hit; // [R5] [R15]

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= `PM_MODE_RST;
            vout_r <= `PM_VOUT_RST;
            otlim_r <= `PM_OTLIM_RST;
            mask_r <= `PM_MASK_RST; // [R4]
        end else if (do_wr) begin
            if (cmd_r == `PM_CMD_MODE) mode_r <= d0_r; // [R8]
            if (cmd_r == `PM_CMD_VOUT) vout_r <= {d1_r, d0_r}; // [R8]
            if (cmd_r == `PM_CMD_OTWARN) otlim_r <= {d1_r, d0_r}; // [R7]
            if (cmd_r == `PM_CMD_MASK) mask_r <= d0_r; // [R5]
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            {scl_d_r, sda_d_r} <= 2'h3;
            state_r <= pm_pkg::ST_IDLE;
            {bit_r, sh_r, crc_r, cmd_r, d0_r, d1_r} <= '0;
            {first_r, rd_r, ara_r, msg_r, cmdv_r, mack_r, sda_oe_r, scl_oe_r} <= '0;
            {nrx_r, idx_r} <= '0;
            {str_r, stot_r, low_r} <= '0;
            status_r <= 8'h00;
            alert_r <= 1'b0;
        end else begin
            {scl_d_r, sda_d_r} <= pins_s;
            state_r <= state_nxt;
            {bit_r, sh_r, crc_r, cmd_r, d0_r, d1_r} <= {bit_nxt, sh_nxt, crc_nxt, cmd_nxt,
                                                       d0_nxt, d1_nxt};
            {first_r, rd_r, ara_r, msg_r} <= {first_nxt, rd_nxt, ara_nxt, msg_nxt};
            {cmdv_r, mack_r, sda_oe_r} <= {cmdv_nxt, mack_nxt, sda_oe_nxt};
            scl_oe_r <= str_nxt != '0;
            {nrx_r, idx_r} <= {nrx_nxt, idx_nxt};
            {str_r, stot_r, low_r} <= {str_nxt, stot_nxt, low_nxt};
            status_r <= status_nxt;
            alert_r <= alert_nxt; // [R3]
        end
    end

    // ****************************************************************
    // Pins: pull low or release only
    // ****************************************************************
    assign o_scl = 1'b0; // [R6]
    assign o_sda = 1'b0; // [R6]
    assign o_alert_output_line = 1'b0; // [R6]
    assign o_scl_oe = scl_oe_r;
    assign o_sda_oe = sda_oe_r;
    assign o_alert_output_line_oe = alert_r; // [R3]
    assign o_vout = '{exponent: mode_r[4:0], mantissa: vout_r};
    assign o_status = status_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_alert_hold;
        @(posedge i_clock) disable iff (!rst_n)
        alert_r && !clr_w && !ara_hit |=> o_alert_output_line_oe;
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("alert dropped"); // [R15]

    property p_alert_set;
        @(posedge i_clock) disable iff (!rst_n)
        |(ev_set & ~mask_r) |=> o_alert_output_line_oe;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("alert not raised"); // [R3]

    property p_mask;
        @(posedge i_clock) disable iff (!rst_n)
        !alert_r && !to_hit && ((ev_set & ~mask_r) == 8'h00) |=> !o_alert_output_line_oe;
    endproperty
    a_mask: assert property (p_mask) else $error("masked event raised alert"); // [R5]

    property p_stretch_ack;
        @(posedge i_clock) disable iff (!rst_n)
        $rose(o_scl_oe) |-> $past(state_r, 2) == pm_pkg::ST_ACK;
    endproperty
    a_stretch_ack: assert property (p_stretch_ack) else $error("stretch without ack"); // [R12]

    property p_stretch_total;
        @(posedge i_clock) disable iff (!rst_n)
        o_scl_oe |-> stot_r < SEXT_LIM;
    endproperty
    a_stretch_total: assert property (p_stretch_total) else $error("stretch budget"); // [R11]

    property p_timeout;
        @(posedge i_clock) disable iff (!rst_n)
        to_hit |=> state_r == pm_pkg::ST_IDLE && !o_sda_oe && !o_scl_oe
                   && o_alert_output_line_oe;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not handled"); // [R13]

    property p_bad_pec;
        @(posedge i_clock) disable iff (!rst_n)
        wr_end && !len_ok && !pec_ok |=> status_r[`PM_ST_CML] && $stable(vout_r) && $stable(mask_r);
    endproperty
    a_bad_pec: assert property (p_bad_pec) else $error("bad packet committed"); // [R2]

    property p_pins;
        @(posedge i_clock) disable iff (!rst_n)
        !o_scl && !o_sda && !o_alert_output_line;
    endproperty
    a_pins: assert property (p_pins) else $error("pin driven high"); // [R6]

    property p_ot;
        @(posedge i_clock) disable iff (!rst_n)
        ot_hit |=> status_r[`PM_ST_OT];
    endproperty
    a_ot: assert property (p_ot) else $error("limit not flagged"); // [R7]

    c_write: cover property (@(posedge i_clock) disable iff (!rst_n) do_wr);
    c_stretch: cover property (@(posedge i_clock) disable iff (!rst_n) $rose(o_scl_oe));
    c_read: cover property (@(posedge i_clock) disable iff (!rst_n)
        state_r == pm_pkg::ST_TXACK && idx_r == 2'h3);
    c_timeout: cover property (@(posedge i_clock) disable iff (!rst_n) to_hit);
endmodule

// [bench/pm_host_model.sv]
// Bus host model: drives the clock and data lines of the two-wire link
module pm_host_model (
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_oe,
    output logic o_sda_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
    end
    // ******************************
    // Line phases
    // ******************************
    // Low phase with data lo, high phase moves data to hi; one call per bit or framing
    task automatic phase(input logic lo, input logic hi, output logic r);
        #1 o_scl_oe = 1'b1;
        #20;
        o_sda_oe = lo;
        #60;
        o_scl_oe = 1'b0;
        // Target may stretch; no clock pulse until the line is really high
        for (int n = 0; n < 99 && i_scl !== 1'b1; n++) #10;
        if (i_scl !== 1'b1) pm_serial_target_tb.errors++;
        r = i_sda;
        #40;
        o_sda_oe = hi;
        #39;
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--) phase(~d[i], ~d[i], q[i]);
        phase(~a, ~a, k);
    endtask
    task automatic hold(input int ns);
        #1 o_scl_oe = 1'b1;
        #ns;
    endtask
endmodule

// [bench/pm_serial_target_tb.sv]
// Self-checking bench of the management serial target
`include "pm_cfg.svh"
module pm_serial_target_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic [5:0] cond = 6'h00;
    logic h_scl_oe, h_sda_oe, d_scl_oe, d_sda_oe, d_scl, d_sda, d_al, d_al_oe, k;
    logic [7:0] status, crc, q;
    pm_pkg::vout_set_s vout;
    pm_pkg::telemetry_s tele;
    int errors = 0;
    int n_compared = 0;
    int st_cnt = 0;
    // Wired-AND with pull-ups: a released line reads high
    wire scl = ~(h_scl_oe | d_scl_oe);
    wire sda = ~(h_sda_oe | d_sda_oe);
    // Negative stage reading would win an unsigned maximum
    assign tele = {11'h7F0, 11'h020, 11'h050, 11'h019, 11'h02D};
    pm_serial_target #(.TIMEOUT_CYC(2000), .SEXT_CYC(40)) pm_serial_target_inst (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(scl), .o_scl(d_scl),
        .o_scl_oe(d_scl_oe), .i_sda(sda), .o_sda(d_sda), .o_sda_oe(d_sda_oe),
        .o_alert_output_line(d_al), .o_alert_output_line_oe(d_al_oe),
        .i_telemetry(tele), .i_cond_set(cond), .o_vout(vout), .o_status(status));
    pm_host_model pm_host_model_inst (
        .i_scl(scl), .i_sda(sda), .o_scl_oe(h_scl_oe), .o_sda_oe(h_sda_oe));
    initial forever #5 i_clock = ~i_clock;
    always @(posedge i_clock) if (d_scl_oe) st_cnt <= st_cnt + 1;
    // ******************************
    // Helpers
    // ******************************
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
        return x;
    endfunction
    task automatic sb(input logic [7:0] d, input logic e);
        crc = crc8(crc, d);
        pm_host_model_inst.xfer(d, 1'b1, q, k);
        chk("ack", e, k);
    endtask
    // p: 0 no error code, 1 good code, 2 corrupted code
    task automatic wr(input logic [7:0] c, input logic [15:0] w, input int n, input int p);
        crc = 8'h00;
        st_cnt = 0;
        pm_host_model_inst.phase(1'b0, 1'b1, k);
        sb({`PM_DEV_ADDR, 1'b0}, 1'b0);
        sb(c, 1'b0);
        for (int i = 0; i < n; i++) sb(w[8*i +: 8], 1'b0);
        if (p == 1) sb(crc, 1'b0);
        if (p == 2) pm_host_model_inst.xfer(crc ^ 8'h01, 1'b1, q, k);
        pm_host_model_inst.phase(1'b1, 1'b0, k);
        repeat (6) @(posedge i_clock);
        chk("stretch budget", 1'b1, st_cnt > 0 && st_cnt <= 40);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] w;
        crc = 8'h00;
        pm_host_model_inst.phase(1'b0, 1'b1, k);
        sb({`PM_DEV_ADDR, 1'b0}, 1'b0);
        sb(c, 1'b0);
        pm_host_model_inst.phase(1'b0, 1'b1, k);
        sb({`PM_DEV_ADDR, 1'b1}, 1'b0);
        pm_host_model_inst.xfer(8'hFF, 1'b0, w[7:0], k);
        pm_host_model_inst.xfer(8'hFF, 1'b0, w[15:8], k);
        pm_host_model_inst.xfer(8'hFF, 1'b1, q, k);
        pm_host_model_inst.phase(1'b1, 1'b0, k);
        chk("read word", e, w);
        chk("read code", crc8(crc8(crc, w[7:0]), w[15:8]), q);
    endtask
    task automatic pulse(input int b);
        @(posedge i_clock) #1 cond[b] = 1'b1;
        @(posedge i_clock) #1 cond[b] = 1'b0;
        repeat (3) @(posedge i_clock);
    endtask
    // ******************************
    // Scenarios
    // ******************************
    task automatic t_alert();
        pulse(0);
        chk("status", 8'h04, status);
        chk("alert", 1'b1, d_al_oe);
        repeat (50) @(posedge i_clock);
        chk("alert held", 1'b1, d_al_oe);
        wr(`PM_CMD_CLEAR, 16'h0000, 0, 0);
        chk("alert cleared", 1'b0, d_al_oe);
        chk("status cleared", 8'h00, status);
    endtask
    task automatic t_mask();
        wr(`PM_CMD_MASK, 16'h0004, 1, 1);
        pulse(0);
        chk("masked status", 8'h04, status);
        chk("masked alert", 1'b0, d_al_oe);
        pulse(1);
        chk("unmasked alert", 1'b1, d_al_oe);
        wr(`PM_CMD_CLEAR, 16'h0000, 0, 0);
        wr(`PM_CMD_MASK, 16'h0000, 1, 0);
    endtask
    task automatic t_vout();
        wr(`PM_CMD_VOUT, 16'h1234, 2, 1);
        chk("vout", {5'h17, 16'h1234}, vout);
        rd(`PM_CMD_VOUT, 16'h1234);
        wr(`PM_CMD_VOUT, 16'h5678, 2, 2);
        chk("vout kept", {5'h17, 16'h1234}, vout);
        chk("code fault", 1'b1, status[0]);
        wr(`PM_CMD_CLEAR, 16'h0000, 0, 0);
    endtask
    task automatic t_timeout();
        pm_host_model_inst.phase(1'b0, 1'b1, k);
        sb({`PM_DEV_ADDR, 1'b0}, 1'b0);
        pm_host_model_inst.hold(25000);
        chk("timeout alert", 1'b1, d_al_oe);
        chk("lines freed", 2'h0, {d_scl_oe, d_sda_oe});
        chk("timeout status", 1'b1, status[0]);
        pm_host_model_inst.phase(1'b1, 1'b0, k);
        wr(`PM_CMD_CLEAR, 16'h0000, 0, 0);
        chk("alert after clear", 1'b0, d_al_oe);
    endtask
    task automatic t_limit();
        wr(`PM_CMD_OTWARN, 16'h0040, 2, 0);
        chk("limit hit", 2'h3, {status[1], d_al_oe});
        wr(`PM_CMD_OTWARN, 16'h03FF, 2, 1);
        wr(`PM_CMD_CLEAR, 16'h0000, 0, 0);
        chk("limit cleared", 8'h00, status);
        wr(`PM_CMD_MODE, 16'h0014, 1, 0);
        chk("mode exponent", 5'h14, vout.exponent);
    endtask
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #900000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge i_clock);
        #1 i_rst_n = 1'b1;
        repeat (10) @(posedge i_clock);
        chk("reset vout", {5'h17, 16'h0000}, vout);
        chk("reset outputs", 11'h000, {status, d_scl_oe, d_sda_oe, d_al_oe});
        t_alert();
        t_mask();
        t_vout();
        rd(`PM_CMD_TEMP1, 16'h0050);
        rd(`PM_CMD_TEMP2, 16'h002D);
        crc = 8'h00;
        pm_host_model_inst.phase(1'b0, 1'b1, k);
        sb({7'h41, 1'b0}, 1'b1);
        pm_host_model_inst.phase(1'b1, 1'b0, k);
        t_limit();
        t_timeout();
        chk("open drain", 3'h0, {d_scl, d_sda, d_al});
        report_and_stop();
    end
endmodule
